//--- hdl/audio_converter_control.sv
`default_nettype none
module audio_converter_control (
   // Clock, reset and enable.
   input  wire logic        core_clk_in,
   input  wire logic        nrst_in,
   input  wire logic        ce_in,
   // Register port.
   input  wire logic [1:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // Sample stream to the analog stage.
   output logic             code_valid_out,
   input  wire logic        code_ready_in,
   output logic      [11:0] audio_code_out,
   output logic      [2:0]  volume_level_out,
   // Shared pin steering and buffer-full flag.
   output logic             converter_on_bit_out,
   output logic             pin_alt_select_out,
   output logic             fifo_full_out
);
   // ****************************************************************
   // Register state.
   // ****************************************************************
   logic [3:0] audio_code_lower_bits, next_audio_code_lower_bits;
   logic [7:0] audio_code_upper_bits, next_audio_code_upper_bits;
   logic [2:0] volume_level_field, next_volume_level_field;
   logic       converter_on_bit, next_converter_on_bit;
   logic [7:0] next_rdata;
   logic       push;
   logic       take;
   logic       load;
   logic       fifo_ready;
   logic       fifo_valid;
   logic [11:0] fifo_data;

   function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
      return a == r;
   endfunction

   // ****************************************************************
   // Register writes and reads.
   // ****************************************************************
   always_comb begin
      next_audio_code_lower_bits = audio_code_lower_bits;
      next_audio_code_upper_bits = audio_code_upper_bits;
      next_volume_level_field    = volume_level_field;
      next_converter_on_bit      = converter_on_bit;
      push                       = 1'b0;
      next_rdata                 = 8'h00;
      take                       = code_valid_out & code_ready_in;
      load                       = converter_on_bit & fifo_valid & (~code_valid_out | take);
      if (wr_in) begin
         if (hit(addr_in, audio_conv_pkg::ADDR_AUDIO_CODE_LOW)) begin
            next_audio_code_lower_bits =
               wdata_in[audio_conv_pkg::LOW_NIBBLE_MSB:audio_conv_pkg::LOW_NIBBLE_LSB];
         end
         if (hit(addr_in, audio_conv_pkg::ADDR_AUDIO_CODE_HIGH)) begin
            next_audio_code_upper_bits = wdata_in;
            push = converter_on_bit;
         end
         if (hit(addr_in, audio_conv_pkg::ADDR_CONVERTER_CTRL)) begin
            next_volume_level_field =
               wdata_in[audio_conv_pkg::VOLUME_MSB:audio_conv_pkg::VOLUME_LSB];
            next_converter_on_bit = wdata_in[audio_conv_pkg::ENABLE_BIT];
         end
      end
      if (rd_in) begin
         case (addr_in)
            audio_conv_pkg::ADDR_AUDIO_CODE_LOW: begin
               next_rdata = {audio_code_lower_bits, 4'h0} & audio_conv_pkg::LOW_READ_MASK;
            end
            audio_conv_pkg::ADDR_AUDIO_CODE_HIGH: begin
               next_rdata = audio_code_upper_bits;
            end
            audio_conv_pkg::ADDR_CONVERTER_CTRL: begin
               next_rdata = {volume_level_field, 4'h0, converter_on_bit}
                            & audio_conv_pkg::CTRL_READ_MASK;
            end
            audio_conv_pkg::ADDR_STATUS: begin
               next_rdata = {6'h00, fifo_valid, ~fifo_ready};
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         audio_code_lower_bits <= audio_conv_pkg::RESET_VALUE[3:0];
         audio_code_upper_bits <= audio_conv_pkg::RESET_VALUE;
         volume_level_field    <= audio_conv_pkg::RESET_VALUE[2:0];
         converter_on_bit      <= 1'b0;
         rdata_out             <= 8'h00;
         converter_on_bit_out  <= 1'b0;
         pin_alt_select_out    <= 1'b0;
         volume_level_out      <= 3'h0;
         code_valid_out        <= 1'b0;
         audio_code_out        <= 12'h000;
         fifo_full_out         <= 1'b0;
      end else if (ce_in) begin
         audio_code_lower_bits <= next_audio_code_lower_bits;
         audio_code_upper_bits <= next_audio_code_upper_bits;
         volume_level_field    <= next_volume_level_field;
         converter_on_bit      <= next_converter_on_bit;
         rdata_out             <= next_rdata;
         converter_on_bit_out  <= next_converter_on_bit;
         pin_alt_select_out    <= ~next_converter_on_bit;
         volume_level_out      <= next_volume_level_field;
         code_valid_out        <= converter_on_bit & (load | (code_valid_out & ~take));
         audio_code_out        <= ~converter_on_bit ? 12'h000
                                  : (load ? fifo_data : audio_code_out);
         fifo_full_out         <= ~fifo_ready;
      end
   end

   // ****************************************************************
   // Sample buffer between register port and analog stage.
   // ****************************************************************
   sample_fifo #(
      .WIDTH (audio_conv_pkg::FIFO_WIDTH),
      .DEPTH (audio_conv_pkg::FIFO_DEPTH)
   ) u_fifo (
      .core_clk_in   (core_clk_in),
      .nrst_in       (nrst_in),
      .ce_in         (ce_in),
      .in_valid_in   (push),
      .in_ready_out  (fifo_ready),
      .in_data_in    ({next_audio_code_upper_bits, audio_code_lower_bits}),
      .out_valid_out (fifo_valid),
      .out_ready_in  (load),
      .out_data_out  (fifo_data)
   );
endmodule // audio_converter_control
`default_nettype wire

//--- hdl/audio_conv_pkg.sv
`default_nettype none
package audio_conv_pkg;
   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [1:0] ADDR_AUDIO_CODE_LOW  = 2'h0;
   localparam logic [1:0] ADDR_AUDIO_CODE_HIGH = 2'h1;
   localparam logic [1:0] ADDR_CONVERTER_CTRL  = 2'h2;
   localparam logic [1:0] ADDR_STATUS          = 2'h3;
   // ****************************************************************
   // Fields and reset values.
   // ****************************************************************
   localparam int         LOW_NIBBLE_MSB  = 7;
   localparam int         LOW_NIBBLE_LSB  = 4;
   localparam int         VOLUME_MSB      = 7;
   localparam int         VOLUME_LSB      = 5;
   localparam int         ENABLE_BIT      = 0;
   localparam logic [7:0] RESET_VALUE     = 8'h00;
   localparam logic [7:0] LOW_READ_MASK   = 8'hf0;
   localparam logic [7:0] CTRL_READ_MASK  = 8'he1;
   localparam int         CODE_WIDTH      = 12;
   localparam int         FIFO_WIDTH      = 12;
   localparam int         FIFO_DEPTH      = 8;
   localparam int         FIFO_AW         = 3;
endpackage
`default_nettype wire

//--- hdl/sample_mem.sv
`default_nettype none
module sample_mem (
   // Clock.
   input  wire logic        core_clk_in,
   input  wire logic        ce_in,
   // Write port.
   input  wire logic        wr_en_in,
   input  wire logic [2:0]  wr_addr_in,
   input  wire logic [11:0] wr_data_in,
   // Read port.
   input  wire logic [2:0]  rd_addr_in,
   output logic      [11:0] rd_data_out
);
   logic [11:0] mem [0:7];
   logic [11:0] next_rd_data;

   always_comb begin
      next_rd_data = mem[rd_addr_in];
   end

   always_ff @(posedge core_clk_in) begin
      if (ce_in) begin
         if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
         end
         rd_data_out <= next_rd_data;
      end
   end
endmodule // sample_mem
`default_nettype wire

//--- hdl/sample_fifo.sv
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic             core_clk_in,
   input  wire logic             nrst_in,
   input  wire logic             ce_in,
   // Fill side.
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side.
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]   count, next_count;
   logic          push, pop;
   logic             bypass;
   logic [WIDTH-1:0] bypass_data;
   logic [WIDTH-1:0] mem_rd_data;

   // ****************************************************************
   // Storage; its read data come out of a register.
   // ****************************************************************
   sample_mem u_mem (
      .core_clk_in (core_clk_in),
      .ce_in       (ce_in),
      .wr_en_in    (push),
      .wr_addr_in  (wr_ptr),
      .wr_data_in  (in_data_in),
      .rd_addr_in  (next_rd_ptr),
      .rd_data_out (mem_rd_data)
   );

   // A word pushed into an otherwise empty buffer is shown from the bypass register.
   assign out_data_out = bypass ? bypass_data : mem_rd_data;

   // ****************************************************************
   // Pointers; storage is addressed with the next read pointer, so its registered read data match the read pointer.
   // ****************************************************************
   always_comb begin
      push         = in_valid_in && (count != DEPTH[AW:0]);
      pop          = out_ready_in && (count != '0);
      next_wr_ptr  = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr  = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count   = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         wr_ptr        <= '0;
         rd_ptr        <= '0;
         count         <= '0;
         in_ready_out  <= 1'b0;
         out_valid_out <= 1'b0;
         bypass        <= 1'b0;
         bypass_data   <= '0;
      end else if (ce_in) begin
         wr_ptr        <= next_wr_ptr;
         rd_ptr        <= next_rd_ptr;
         count         <= next_count;
         in_ready_out  <= (next_count != DEPTH[AW:0]);
         out_valid_out <= (next_count != '0);
         bypass        <= push && (next_count == {{AW{1'b0}}, 1'b1});
         bypass_data   <= in_data_in;
      end
   end
endmodule // sample_fifo
`default_nettype wire

//--- testbench/audio_conv_props.sv
`default_nettype none
module audio_conv_props (
   // Clock, reset and register port.
   input wire logic        core_clk_in,
   input wire logic        nrst_in,
   input wire logic [1:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rdata_out,
   // Stream and steering.
   input wire logic        code_valid_out,
   input wire logic        code_ready_in,
   input wire logic [11:0] audio_code_out,
   input wire logic [2:0]  volume_level_out,
   input wire logic        converter_on_bit_out,
   input wire logic        pin_alt_select_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Port relations.
   // ****************************************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);
   a_pin_steer: assert property ($past(nrst_in) |-> pin_alt_select_out != converter_on_bit_out)
      else $error("pin steering disagrees with enable");
   a_off_quiet: assert property (!converter_on_bit_out && !$past(converter_on_bit_out)
      |-> !code_valid_out && audio_code_out == 12'h000)
      else $error("code output active while converter off");
   a_code_hold: assert property (code_valid_out && $past(code_valid_out) && !code_ready_in
      && !$past(code_ready_in) && !wr_in |=> code_valid_out && $stable(audio_code_out))
      else $error("stalled code changed");
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside read cycle");
   a_low_mask: assert property ($past(rd_in) && $past(addr_in) == 2'h0 |-> rdata_out[3:0] == 4'h0)
      else $error("low code register bits three to zero not zero");
   a_ctrl_mask: assert property ($past(rd_in) && $past(addr_in) == 2'h2 |-> rdata_out[4:1] == 4'h0)
      else $error("control register bits four to one not zero");
   a_enable_set: assert property (wr_in && addr_in == 2'h2 && wdata_in[0] |-> ##[1:2] converter_on_bit_out)
      else $error("enable write did not turn converter on");
   a_reset_clear: assert property (disable iff (1'b0) !nrst_in
      |=> volume_level_out == 3'h0 && !converter_on_bit_out && !code_valid_out)
      else $error("outputs not cleared by reset");
endmodule // audio_conv_props
bind audio_converter_control audio_conv_props u_props (.core_clk_in, .nrst_in, .addr_in,
   .wdata_in, .wr_in, .rd_in, .rdata_out, .code_valid_out, .code_ready_in, .audio_code_out,
   .volume_level_out, .converter_on_bit_out, .pin_alt_select_out);
`default_nettype wire

//--- testbench/analog_stage_model.sv
`default_nettype none
module analog_stage_model (
   // Clock and stall control.
   input  wire logic        core_clk_in,
   input  wire logic        stall_in,
   // Code stream.
   input  wire logic        valid_in,
   input  wire logic [11:0] code_in,
   output logic             ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] got [0:15];
   int          count = 0;
   assign ready_out = !stall_in;
   // Takes a code only while the block offers one.
   always @(posedge core_clk_in) begin
      if (valid_in && ready_out) begin
         got[count] <= code_in;
         count <= count + 1;
      end
   end
endmodule // analog_stage_model
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, stall = 0;
   logic [1:0]  addr_in = 2'h0;
   logic [7:0]  wdata_in = 8'h00, rd_val, rdata_out;
   logic        code_valid_out, code_ready_in, on_bit, pin_alt, fifo_full;
   logic [11:0] audio_code_out;
   logic [2:0]  volume;
   int          err_total = 0, check_count = 0;
   audio_converter_control u_dut (.core_clk_in, .nrst_in, .ce_in(1'b1), .addr_in, .wdata_in,
      .wr_in, .rd_in, .rdata_out, .code_valid_out, .code_ready_in, .audio_code_out,
      .volume_level_out(volume), .converter_on_bit_out(on_bit), .pin_alt_select_out(pin_alt),
      .fifo_full_out(fifo_full));
   analog_stage_model u_stage (.core_clk_in, .stall_in(stall), .valid_in(code_valid_out),
      .code_in(audio_code_out), .ready_out(code_ready_in));
   initial forever #25 core_clk_in = ~core_clk_in;
   // ****************************************************************
   // Bus cycles and comparison.
   // ****************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge core_clk_in);
      rd_in <= 1'b1; addr_in <= a;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
      #1 rd_val = rdata_out;
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk_in);
      #1;
   endtask
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset();
      for (int a = 0; a < 3; a++) begin
         rd(a[1:0]);
         check(rd_val, 16'h0000);
      end
      check({pin_alt, on_bit, volume}, 16'h0010);
   endtask
   task automatic t_masks();
      wr(2'h0, 8'hff);
      rd(2'h0);
      check(rd_val, 16'h00f0);
      wr(2'h2, 8'hff);
      rd(2'h2);
      check(rd_val, 16'h00e1);
      check({pin_alt, on_bit}, 16'h0001);
      wr(2'h2, 8'h00);
      settle();
      check({pin_alt, on_bit}, 16'h0002);
   endtask
   task automatic t_volume();
      for (int v = 0; v < 8; v++) begin
         wr(2'h2, {v[2:0], 5'h00});
         settle();
         check(volume, v[15:0]);
      end
   endtask
   task automatic t_stream();
      int n;
      stall <= 1'b1;
      wr(2'h2, 8'h01);
      for (int i = 0; i < 10; i++) begin
         wr(2'h0, {i[3:0], 4'h0});
         wr(2'h1, 8'h10 + i[7:0]);
      end
      settle();
      check(fifo_full, 16'h0001);
      rd(2'h3);
      check(rd_val, 16'h0003);
      stall <= 1'b0;
      for (n = 0; n < 60 && u_stage.count < 9; n++) @(posedge core_clk_in);
      settle();
      check(u_stage.count, 16'h0009);
      for (int i = 0; i < 9; i++) check(u_stage.got[i], {8'h10 + i[7:0], i[3:0]});
      rd(2'h3);
      check(rd_val, 16'h0000);
   endtask
   task automatic t_off();
      wr(2'h2, 8'h00);
      wr(2'h0, 8'h50);
      wr(2'h1, 8'haa);
      settle();
      check({code_valid_out, audio_code_out}, 16'h0000);
      check(u_stage.count, 16'h0009);
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      t_reset();
      t_masks();
      t_volume();
      t_stream();
      t_off();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk_in);
      err_total++;
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
